// ===== include/fri_pkg.sv
// Purpose: shared constants and types for the frequency reference input control
// Assumes: frequencies are unsigned counts of 0.01 Hz
// Notes:   function codes are the selector values of the contact inputs
package fri_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NUM_IN = 5;
  localparam int FW     = 16;
  localparam int SEL_W  = 8;
  localparam int TICK_W = 10;

  typedef logic [FW-1:0]    fri_freq_t;
  typedef logic [SEL_W-1:0] fri_sel_t;

  // ----------------------------------------------------------------
  // contact input function codes
  // ----------------------------------------------------------------
  localparam fri_sel_t FN_RAMP_HOLD = 8'h0a;
  localparam fri_sel_t FN_UP        = 8'h10;
  localparam fri_sel_t FN_DOWN      = 8'h11;
  localparam fri_sel_t FN_TRIM_INC  = 8'h1c;
  localparam fri_sel_t FN_TRIM_DEC  = 8'h1d;

  // reference source codes
  localparam logic [1:0] SRC_A1 = 2'h1;
  localparam logic [1:0] SRC_A2 = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_US = 100;
  localparam int TICK_CYCLES    = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam fri_freq_t FMAX_REF         = 16'h1770;
  localparam int        TRIM_DEFAULT_PCT = 10;
  localparam fri_freq_t TRIM_STEP_RST    = FW'((int'(FMAX_REF) * TRIM_DEFAULT_PCT) / 100);
  localparam logic      HOLD_SEL_RST     = 1'b0;
  localparam fri_freq_t FREQ_ZERO        = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_START = 2'b01,
    PH_RUN   = 2'b10
  } fri_phase_e;

  typedef struct packed {
    logic rampHold;
    logic up;
    logic down;
    logic trimInc;
    logic trimDec;
  } fri_func_s;

  typedef struct packed {
    fri_phase_e        phase;
    logic [TICK_W-1:0] tickCnt;
    logic              tick;
    logic              run;
    fri_func_s         act;
    fri_func_s         actPrev;
    fri_freq_t         outFreq;
    fri_freq_t         udRef;
    fri_freq_t         target;
    logic              holdSel;
    fri_freq_t         trimStep;
    logic              cfgErr;
    logic              speedAgree;
    logic              accel;
    logic              decel;
  } fri_state_s;

  typedef struct packed {
    logic      valid;
    fri_freq_t data;
  } fri_store_s;

endpackage : fri_pkg

// ===== hw/fri_ref_store.sv
// Purpose: retained store for the held frequency reference
// Assumes: porResetn is asserted only at power-up, never by the drive's own reset
// Notes:   read data come from a register; valid stays low until the first write
`timescale 1ns/100ps
module fri_ref_store
  import fri_pkg::*;
(
  // clock and power-on reset
  input  wire logic      clk,
  input  wire logic      porResetn,
  // write side
  input  wire logic      wrEn,
  input  wire fri_freq_t wrData,
  // read side
  output fri_store_s     rdData
);

  fri_store_s mem_q;
  fri_store_s mem_d;

  always_comb begin
    mem_d = mem_q;
    if (wrEn) begin
      mem_d.valid = 1'b1;
      mem_d.data  = wrData;
    end
  end

  // the drive reset leaves this alone, so the value survives a restart
  always_ff @(posedge clk or negedge porResetn) begin
    if (!porResetn) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rdData = mem_q;

endmodule : fri_ref_store

// ===== hw/fri_freq_ref_ctrl.sv
// Purpose: frequency reference handling from multi-function contact inputs
// Assumes: all inputs synchronous to clk; accel/decel times given as steps per tick
// Notes:   one update of the ramp per control tick
`timescale 1ns/100ps
module fri_freq_ref_ctrl
  import fri_pkg::*;
(
  // clock and resets
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  powerOnResetn,
  // contact inputs and their function selectors
  input  wire logic [NUM_IN-1:0]     contactIn,
  input  wire fri_sel_t [NUM_IN-1:0] inputFunctionSelect,
  input  wire logic                  runCmd,
  // reference sources
  input  wire logic [1:0]            referenceSource,
  input  wire fri_freq_t             analogInputOne,
  input  wire fri_freq_t             analogInputTwo,
  input  wire logic                  multiStepSel,
  input  wire fri_freq_t             multiStepRef,
  // limits and rates
  input  wire fri_freq_t             referenceUpperLimit,
  input  wire fri_freq_t             referenceLowerLimit,
  input  wire fri_freq_t             referenceLowerLimitAlt,
  input  wire logic                  lowerLimitAltSel,
  input  wire fri_freq_t             accelStep,
  input  wire fri_freq_t             decelStep,
  // settings
  input  wire logic                  referenceHoldSelectIn,
  input  wire logic                  referenceHoldSelectWr,
  input  wire fri_freq_t             trimStepIn,
  input  wire logic                  trimStepWr,
  // status
  output fri_freq_t                  outputFreq,
  output fri_freq_t                  freqRef,
  output logic                       speedAgree,
  output logic                       accelerating,
  output logic                       decelerating,
  output logic                       inputConfigError,
  output logic                       referenceHoldSelect,
  output fri_freq_t                  trimStep
);

  fri_state_s st_q;
  fri_state_s st_d;
  fri_store_s store;
  logic       storeWr;
  fri_freq_t  storeData;

  // ----------------------------------------------------------------
  // function decode per contact
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] isHold, isUp, isDown, isInc, isDec;

  for (genvar i = 0; i < NUM_IN; i++) begin : g_decode
    assign isHold[i] = inputFunctionSelect[i] == FN_RAMP_HOLD;
    assign isUp[i]   = inputFunctionSelect[i] == FN_UP;
    assign isDown[i] = inputFunctionSelect[i] == FN_DOWN;
    assign isInc[i]  = inputFunctionSelect[i] == FN_TRIM_INC;
    assign isDec[i]  = inputFunctionSelect[i] == FN_TRIM_DEC;
  end

  logic asgHold, asgUp, asgDown, asgInc, asgDec, cfgErrNow, udMode, trimMode;
  assign asgHold   = |isHold;
  assign asgUp     = |isUp;
  assign asgDown   = |isDown;
  assign asgInc    = |isInc;
  assign asgDec    = |isDec;
  assign cfgErrNow = (asgUp ^ asgDown) | ((asgUp | asgDown) & asgHold) | (asgInc ^ asgDec);
  assign udMode    = asgUp & asgDown & !cfgErrNow;
  assign trimMode  = asgInc & asgDec & !cfgErrNow;

  // ----------------------------------------------------------------
  // reference selection
  // ----------------------------------------------------------------
  fri_freq_t anaRef, baseRef, lowLim, lowCfg, trimRef;
  logic      isAnalog, trimHold;

  always_comb begin
    isAnalog = (referenceSource == SRC_A1) || (referenceSource == SRC_A2);
    anaRef   = (referenceSource == SRC_A2) ? analogInputTwo : analogInputOne;
    baseRef  = (multiStepSel && !udMode) ? multiStepRef : anaRef;
    lowCfg   = lowerLimitAltSel ? referenceLowerLimitAlt : referenceLowerLimit;
    lowLim   = (analogInputOne > lowCfg) ? analogInputOne : lowCfg;
    trimRef  = baseRef;
    trimHold = 1'b0;
    if (trimMode && isAnalog && baseRef != FREQ_ZERO) begin
      if (st_q.act.trimInc && !st_q.act.trimDec) begin
        trimRef = ({1'b0, baseRef} + {1'b0, st_q.trimStep} > {1'b0, referenceUpperLimit}) ?
                  referenceUpperLimit : FW'(baseRef + st_q.trimStep);
      end else if (st_q.act.trimDec && !st_q.act.trimInc) begin
        trimRef = (baseRef < st_q.trimStep) ? FREQ_ZERO : FW'(baseRef - st_q.trimStep);
      end else begin
        trimHold = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  logic      upOnly, downOnly, held, stopped;
  fri_freq_t tgt, udNext, startRef;
  logic [FW:0] sum;

  always_comb begin
    st_d      = st_q;
    storeWr   = 1'b0;
    storeData = st_q.outFreq;
    upOnly    = st_q.act.up && !st_q.act.down;
    downOnly  = st_q.act.down && !st_q.act.up;
    held      = st_q.act.rampHold && st_q.run && st_q.phase != PH_IDLE;
    stopped   = st_q.phase == PH_IDLE && st_q.outFreq == FREQ_ZERO;
    startRef  = (store.valid && st_q.holdSel) ? store.data : FREQ_ZERO;
    tgt       = st_q.target;
    udNext    = st_q.udRef;
    sum       = '0;

    // sample contacts and tick on every clock
    st_d.act     = '{rampHold: |(contactIn & isHold), up: |(contactIn & isUp),
                     down: |(contactIn & isDown), trimInc: |(contactIn & isInc),
                     trimDec: |(contactIn & isDec)};
    st_d.actPrev = st_q.act;
    st_d.run     = runCmd;
    st_d.cfgErr  = cfgErrNow;
    st_d.tick    = st_q.tickCnt == TICK_LAST;
    st_d.tickCnt = st_d.tick ? '0 : TICK_W'(st_q.tickCnt + 1'b1);

    // settings only while stopped
    if (stopped && referenceHoldSelectWr) begin
      st_d.holdSel = referenceHoldSelectIn;
    end
    if (stopped && trimStepWr) begin
      st_d.trimStep = trimStepIn;
    end

    // pressing raise or lower during run wipes the stored reference
    if (udMode && st_q.run && st_q.phase == PH_RUN &&
        ((st_q.act.up && !st_q.actPrev.up) || (st_q.act.down && !st_q.actPrev.down))) begin
      storeWr   = 1'b1;
      storeData = FREQ_ZERO;
    end

    if (st_q.tick) begin
      case (st_q.phase)
        PH_IDLE: begin
          tgt = FREQ_ZERO;
          if (st_q.run && !st_q.cfgErr) begin
            st_d.phase = PH_START;
            if (udMode) begin
              udNext = (startRef > lowLim) ? startRef : lowLim;
            end else begin
              tgt = (startRef != FREQ_ZERO) ? startRef : trimRef;
            end
          end
        end
        PH_START: begin
          if (st_q.outFreq == (udMode ? st_q.udRef : st_q.target)) begin
            st_d.phase = PH_RUN;
          end
          // trim and analog changes still steer a plain start; a stored restart keeps its value
          if (!udMode && startRef == FREQ_ZERO && !trimHold) begin
            tgt = trimRef;
          end
        end
        PH_RUN: begin
          if (udMode) begin
            if (upOnly) begin
              sum    = {1'b0, st_q.udRef} + {1'b0, accelStep};
              udNext = (sum > {1'b0, referenceUpperLimit}) ? referenceUpperLimit : sum[FW-1:0];
            end else if (downOnly) begin
              udNext = ({1'b0, st_q.udRef} < {1'b0, lowLim} + {1'b0, decelStep}) ?
                       lowLim : FW'(st_q.udRef - decelStep);
            end else begin
              udNext = st_q.outFreq;
              if (st_q.holdSel && !storeWr) begin
                storeWr = 1'b1;
              end
            end
          end else if (!trimHold) begin
            tgt = trimRef;
          end
          if (held && st_q.holdSel && !storeWr) begin
            storeWr = 1'b1;
          end
        end
        default: st_d.phase = PH_IDLE;
      endcase

      // clamp the raise/lower reference into its window
      if (udNext > referenceUpperLimit) begin
        udNext = referenceUpperLimit;
      end
      if (udNext < lowLim && st_q.phase != PH_IDLE) begin
        udNext = lowLim;
      end
      if (!udMode && tgt > referenceUpperLimit) begin
        tgt = referenceUpperLimit;
      end
      st_d.udRef  = udNext;
      // without this a stopped raise/lower drive would keep its reference and never ramp down
      st_d.target = !st_q.run ? FREQ_ZERO : (udMode ? udNext : tgt);

      // ramp output toward the target unless held
      st_d.accel = 1'b0;
      st_d.decel = 1'b0;
      if (!held) begin
        if (st_q.outFreq < st_d.target) begin
          st_d.accel   = 1'b1;
          st_d.outFreq = (st_d.target - st_q.outFreq > accelStep) ?
                         FW'(st_q.outFreq + accelStep) : st_d.target;
        end else if (st_q.outFreq > st_d.target) begin
          st_d.decel   = 1'b1;
          st_d.outFreq = (st_q.outFreq - st_d.target > decelStep) ?
                         FW'(st_q.outFreq - decelStep) : st_d.target;
        end
      end
      st_d.speedAgree = st_q.run && !st_d.accel && !st_d.decel && !held;
    end

    // a stop wins over ramp hold: drop to idle and ramp down
    if (!st_q.run) begin
      st_d.phase      = PH_IDLE;
      st_d.target     = FREQ_ZERO;
      st_d.speedAgree = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q          <= '0;
      st_q.phase    <= PH_IDLE;
      st_q.holdSel  <= HOLD_SEL_RST;
      st_q.trimStep <= TRIM_STEP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  fri_ref_store u_store (
    .clk       (clk),
    .porResetn (powerOnResetn),
    .wrEn      (storeWr),
    .wrData    (storeData),
    .rdData    (store)
  );

  assign outputFreq          = st_q.outFreq;
  assign freqRef             = st_q.target;
  assign speedAgree          = st_q.speedAgree;
  assign accelerating        = st_q.accel;
  assign decelerating        = st_q.decel;
  assign inputConfigError    = st_q.cfgErr;
  assign referenceHoldSelect = st_q.holdSel;
  assign trimStep            = st_q.trimStep;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence udPress;
    udMode && st_q.run && st_q.phase == PH_RUN && st_q.act.up && !st_q.actPrev.up;
  endsequence

  hold_freezes_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q.tick && held) |=> $stable(outputFreq))
    else $error("output moved during ramp hold");

  stop_beats_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (!st_q.run && st_q.act.rampHold) |=> (st_q.phase == PH_IDLE && freqRef == FREQ_ZERO))
    else $error("stop ignored under ramp hold");

  hold_sel_lock_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_q.phase != PH_IDLE) |=> $stable(referenceHoldSelect))
    else $error("hold selector changed while running");

  cfg_error_a: assert property (@(posedge clk) disable iff (!resetn)
    (asgUp && !asgDown) |=> inputConfigError)
    else $error("lone raise assignment not flagged");

  trim_pair_a: assert property (@(posedge clk) disable iff (!resetn)
    (asgInc != asgDec) |=> inputConfigError)
    else $error("lone trim assignment not flagged");

  ud_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
    (udMode && st_q.tick && st_q.phase == PH_RUN) |=> (st_q.udRef <= $past(referenceUpperLimit)))
    else $error("raise/lower reference above upper limit");

  accel_rate_a: assert property (@(posedge clk) disable iff (!resetn)
    (outputFreq > $past(outputFreq)) |-> (outputFreq - $past(outputFreq) <= $past(accelStep)))
    else $error("acceleration faster than configured step");

  store_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    udPress |-> (storeWr && storeData == FREQ_ZERO) ##1 (store.data == FREQ_ZERO))
    else $error("stored reference not cleared on press");

  trim_floor_a: assert property (@(posedge clk) disable iff (!resetn)
    (trimMode && isAnalog && baseRef != FREQ_ZERO && st_q.act.trimDec && !st_q.act.trimInc &&
     baseRef < st_q.trimStep) |-> trimRef == FREQ_ZERO)
    else $error("negative trimmed reference not zeroed");

  agree_run_a: assert property (@(posedge clk) disable iff (!resetn)
    speedAgree |-> ($past(st_q.run) && !accelerating && !decelerating))
    else $error("speed agree without run or while ramping");

endmodule : fri_freq_ref_ctrl

// ===== test/fri_contact_drv.sv
// Purpose: external control equipment that drives the contact inputs
// Assumes: contacts change only just after a rising clock edge
// Notes:   contacts are plain levels held until the next call
`timescale 1ns/100ps
module fri_contact_drv
  import fri_pkg::*;
(
  // clock
  input  wire logic         clk,
  // contact levels
  output logic [NUM_IN-1:0] contactIn
);
  logic [NUM_IN-1:0] contactQ = '0;

  assign contactIn = contactQ;

  // ----------------------------------------------------------------
  // one contact per call, so two changes never share an edge
  // ----------------------------------------------------------------
  task automatic drive(input int idx, input logic lvl);
    @(posedge clk);
    contactQ[idx] <= lvl;
  endtask : drive
endmodule : fri_contact_drv

// ===== test/fri_freq_ref_ctrl_tb.sv
// Purpose: self-checking bench for the frequency reference input control
// Assumes: one control tick every TICK_CYCLES clocks
// Notes:   step sizes are round so that every ramp lands exactly on its target
`timescale 1ns/100ps
module fri_freq_ref_ctrl_tb
  import fri_pkg::*;
();
  logic                  clk = 1'b0, resetn = 1'b0, porResetn = 1'b0;
  logic                  runCmd = 1'b0, msSel = 1'b0, lowAltSel = 1'b0;
  logic                  holdIn = 1'b0, holdWr = 1'b0, trimWr = 1'b0;
  logic [1:0]            srcSel = SRC_A1;
  logic [NUM_IN-1:0]     contactIn;
  fri_sel_t [NUM_IN-1:0] funcSel = '0;
  fri_freq_t             anaOne = 16'h0180, anaTwo = 16'h0300, msRef = 16'h0300;
  fri_freq_t             upLim = 16'h0400, lowLim = 16'h0100, lowAlt = 16'h0000;
  fri_freq_t             accStep = 16'h0080, decStep = 16'h0100, trimIn = 16'h0000;
  fri_freq_t             outFreq, fRef, trimOut;
  logic                  spdAgree, accel, decel, cfgErr, holdSel;
  int                    errCount = 0, nTests = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  fri_contact_drv drv (.clk(clk), .contactIn(contactIn));

  fri_freq_ref_ctrl dut (
    .clk(clk), .resetn(resetn), .powerOnResetn(porResetn), .contactIn(contactIn),
    .inputFunctionSelect(funcSel), .runCmd(runCmd), .referenceSource(srcSel),
    .analogInputOne(anaOne), .analogInputTwo(anaTwo), .multiStepSel(msSel), .multiStepRef(msRef),
    .referenceUpperLimit(upLim), .referenceLowerLimit(lowLim), .referenceLowerLimitAlt(lowAlt),
    .lowerLimitAltSel(lowAltSel), .accelStep(accStep), .decelStep(decStep),
    .referenceHoldSelectIn(holdIn), .referenceHoldSelectWr(holdWr), .trimStepIn(trimIn),
    .trimStepWr(trimWr), .outputFreq(outFreq), .freqRef(fRef), .speedAgree(spdAgree),
    .accelerating(accel), .decelerating(decel), .inputConfigError(cfgErr),
    .referenceHoldSelect(holdSel), .trimStep(trimOut)
  );

  // ----------------------------------------------------------------
  // compare and access tasks
  // ----------------------------------------------------------------
  task automatic chk16(input fri_freq_t got, input fri_freq_t exp, input string what);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp, input string what);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask : chk1

  // whole ticks, so every per-tick update has landed before sampling
  task automatic wt(input int n);
    repeat (n * TICK_CYCLES) @(posedge clk);
    @(negedge clk);
  endtask : wt

  task automatic wrCfg(input logic h, input logic hw, input fri_freq_t t, input logic tw);
    @(posedge clk);
    holdIn <= h;
    holdWr <= hw;
    trimIn <= t;
    trimWr <= tw;
    @(posedge clk);
    holdWr <= 1'b0;
    trimWr <= 1'b0;
    @(negedge clk);
  endtask : wrCfg

  task automatic setSel(input logic [8*NUM_IN-1:0] v);
    @(posedge clk);
    funcSel <= v;
    @(posedge clk);
    @(negedge clk);
  endtask : setSel

  task automatic setRun(input logic v);
    @(posedge clk);
    runCmd <= v;
  endtask : setRun

  task automatic pulseReset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
  endtask : pulseReset

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // watchdog: the sequence needs about 70 ticks
  // ----------------------------------------------------------------
  initial begin : watchdog
    repeat (90 * TICK_CYCLES) @(posedge clk);
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : mainSeq
    logic [8*NUM_IN-1:0] cfgTab [5];
    logic [4:0]          cfgExp;
    fri_freq_t           frozen;
    cfgTab = '{40'h00_0000_0010, 40'h00_000a_1110, 40'h00_0000_001c, 40'h00_1d1c_1110, 40'h00_0000_000a};
    cfgExp = 5'b00111;
    repeat (12) @(posedge clk);
    porResetn <= 1'b1;
    resetn <= 1'b1;
    @(negedge clk);
    chk16(trimOut, TRIM_STEP_RST, "trim step at reset");
    chk1(holdSel, HOLD_SEL_RST, "hold select at reset");
    chk16(outFreq, FREQ_ZERO, "output at reset");
    for (int i = 0; i < 5; i++) begin
      setSel(cfgTab[i]);
      chk1(cfgErr, cfgExp[i], "config error");
    end
    // raise/lower with storage on
    setSel(40'h00_0000_1110);
    wrCfg(1'b1, 1'b1, 16'h0000, 1'b0);
    chk1(holdSel, 1'b1, "hold select write");
    setRun(1'b1);
    wt(5);
    chk16(outFreq, anaOne, "start level");
    chk1(spdAgree, 1'b1, "agree at start level");
    wrCfg(1'b0, 1'b1, 16'h0100, 1'b1);
    chk1(holdSel, 1'b1, "hold select while running");
    chk16(trimOut, TRIM_STEP_RST, "trim step while running");
    @(posedge clk);
    msSel <= 1'b1;
    wt(2);
    chk16(outFreq, anaOne, "multi-step ignored");
    drv.drive(0, 1'b1);
    wt(2);
    chk1(accel, 1'b1, "raise accelerates");
    wt(6);
    chk16(outFreq, upLim, "upper clamp");
    drv.drive(1, 1'b1);
    wt(2);
    chk16(outFreq, upLim, "both held");
    chk1(decel, 1'b0, "no decel when both");
    drv.drive(0, 1'b0);
    drv.drive(1, 1'b0);
    wt(1);
    setRun(1'b0);
    repeat (3) @(negedge clk);
    chk16(fRef, FREQ_ZERO, "stop clears reference");
    chk1(spdAgree, 1'b0, "stop clears agree");
    wt(5);
    chk16(outFreq, FREQ_ZERO, "stopped");
    // control reset only: the retained store survives
    pulseReset();
    wrCfg(1'b1, 1'b1, 16'h0000, 1'b0);
    setRun(1'b1);
    wt(10);
    chk16(outFreq, upLim, "restart at stored");
    drv.drive(1, 1'b1);
    wt(5);
    chk16(outFreq, anaOne, "lower clamp from analog one");
    drv.drive(1, 1'b0);
    msSel <= 1'b0;
    setRun(1'b0);
    wt(3);
    // ramp hold
    pulseReset();
    setSel(40'h00_0000_000a);
    chk1(cfgErr, 1'b0, "ramp hold alone");
    @(posedge clk);
    anaOne <= 16'h0400;
    setRun(1'b1);
    wt(2);
    drv.drive(0, 1'b1);
    wt(1);
    frozen = outFreq;
    wt(3);
    chk16(outFreq, frozen, "ramp frozen");
    chk1(spdAgree, 1'b0, "no agree while frozen");
    drv.drive(0, 1'b0);
    wt(8);
    chk16(outFreq, 16'h0400, "ramp resumed");
    chk1(spdAgree, 1'b1, "agree at reference");
    drv.drive(0, 1'b1);
    setRun(1'b0);
    wt(6);
    chk16(outFreq, FREQ_ZERO, "stop during hold");
    drv.drive(0, 1'b0);
    // trim with the default step
    pulseReset();
    @(posedge clk);
    upLim <= 16'h1770;
    setSel(40'h00_0000_1d1c);
    chk1(cfgErr, 1'b0, "trim pair");
    drv.drive(0, 1'b1);
    setRun(1'b1);
    wt(2);
    chk16(fRef, 16'h0400 + TRIM_STEP_RST, "trim increase");
    drv.drive(0, 1'b0);
    drv.drive(1, 1'b1);
    wt(2);
    chk16(fRef, 16'h01a8, "trim decrease");
    @(posedge clk);
    anaOne <= 16'h0100;
    wt(2);
    chk16(fRef, FREQ_ZERO, "negative trim floors");
    @(posedge clk);
    srcSel <= SRC_A2;
    drv.drive(1, 1'b0);
    drv.drive(0, 1'b1);
    wt(2);
    chk16(fRef, 16'h0558, "trim on analog two");
    drv.drive(1, 1'b1);
    anaTwo <= 16'h0200;
    wt(2);
    chk16(fRef, 16'h0558, "trim both held");
    tally_and_finish();
  end
endmodule : fri_freq_ref_ctrl_tb
